// *** src/ldol_consts.svh ***
/*
 Thresholds, rate limits and field positions for the LED dimming output logic.
 Assumes inclusion by bare name from the package and design files.
*/
`ifndef LDOL_CONSTS_SVH
`define LDOL_CONSTS_SVH
// Analog thresholds as unsigned millivolt codes
`define LDOL_RECOVERY_SENSE_MV    16'h0030
`define LDOL_LOAD_DONE_MV         16'h0009
`define LDOL_SS_DONE_MV           16'h0dac
`define LDOL_FOLD_KNEE_MV         16'h0190
// Frequency scale in percent of full rate
`define LDOL_FREQ_FLOOR_PCT       8'h0a
`define LDOL_FREQ_FULL_PCT        8'h64
// Gate bit positions
`define LDOL_GATE_ONE             0
`define LDOL_GATE_TWO             1
`define LDOL_GATE_THREE           2
`endif

// *** src/ldol_pkg.sv ***
/*
 Types shared by the LED dimming output logic.
 Assumes the constants header is on the include path.
*/
package ldol_pkg;
	`include "ldol_consts.svh"
	// Three dimming lanes, bit 0 is lane one
	typedef struct packed {
		logic three;
		logic two;
		logic one;
	} ldol_dim_t;
	// Start-up sequencing states
	typedef enum logic [1:0] {
		LDOL_IDLE,
		LDOL_RECOVER,
		LDOL_RUN
	} ldol_state_t;
endpackage : ldol_pkg

// *** src/ldol_freq_scale.sv ***
/*
 Frequency foldback scaler: percent of full switching rate from feedback.
 Assumes feedback arrives as an unsigned millivolt code on ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ldol_consts.svh"
module ldol_freq_scale (
	// Clock and control
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	input  wire logic        clkEn,
	// Feedback and result
	input  wire logic [15:0] feedbackMv,
	output logic      [7:0]  freqPct
);
	import ldol_pkg::*;
	logic [15:0] clampMv;
	logic [23:0] scaled;
	// Clamp at knee, map 0..knee onto floor..full linearly
	always_comb begin
		clampMv = (feedbackMv > `LDOL_FOLD_KNEE_MV) ? `LDOL_FOLD_KNEE_MV : feedbackMv;
		scaled  = 24'(clampMv) * 24'(`LDOL_FREQ_FULL_PCT - `LDOL_FREQ_FLOOR_PCT);
	end
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			freqPct <= `LDOL_FREQ_FLOOR_PCT;
		end else if (clkEn) begin
			freqPct <= 8'(`LDOL_FREQ_FLOOR_PCT + 8'(scaled / 24'(`LDOL_FOLD_KNEE_MV)));
		end
	end
endmodule : ldol_freq_scale
`default_nettype wire

// *** src/ldol_top.sv ***
/*
 LED dimming output logic: gate decode, switch enable, start-up recovery,
 soft-start control, sync selection and frequency foldback.
 Assumes all inputs are synchronous digital levels on ref_clk; analog
 quantities arrive as unsigned millivolt codes from converters outside.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ldol_consts.svh"
// Overview of operation
// - All dimming inputs low stops switching and pulls all gates low.
// - First rising input after start or fault starts switching, soft-start, gates high.
// - During recovery ignore inputs and regulate sense at 48mV, eighty percent.
// - Recovery ends at load sense 9mV or soft-start 3.5V, first wins.
// - Gate three wins, then gate two, else gate one follows input one.
// - Sync unused means tied low; rate then comes from resistor only.
// - Synced switch edges follow sync edges after a fixed delay.
// - Rate scales linearly to ten percent floor as feedback drops below 400mV.
// - Any fault discharges soft-start fully; recharge allowed once cleared.
module ldol_top #(
	parameter int SYNC_DELAY = 2
) (
	// Clock and control
	input  wire logic                ref_clk,
	input  wire logic                rst_n,
	input  wire logic                clkEn,
	// Dimming inputs and fault
	input  wire ldol_pkg::ldol_dim_t dimIn,
	input  wire logic                faultIn,
	// Analog codes in millivolts
	input  wire logic [15:0]         loadSenseMv,
	input  wire logic [15:0]         softStartMv,
	input  wire logic [15:0]         feedbackNodeMv,
	// Synchronisation
	input  wire logic                syncIn,
	input  wire logic                oscTick,
	// Outputs
	output ldol_pkg::ldol_dim_t      dimGate,
	output logic                     switchEn,
	output logic                     softStartRelease,
	output logic                     recoveryActive,
	output logic [15:0]              senseLimitMv,
	output logic                     switchEdge,
	output logic [7:0]               freqPct
);
	import ldol_pkg::*;

	// ------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------
	ldol_dim_t   dimMeta_q;
	ldol_dim_t   dimSync_q;
	ldol_dim_t   dimPrev_q;
	logic        anyRise;
	logic        allLow;

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			dimMeta_q <= '0;
			dimSync_q <= '0;
			dimPrev_q <= '0;
		end else if (clkEn) begin
			dimMeta_q <= dimIn;
			dimSync_q <= dimMeta_q;
			dimPrev_q <= dimSync_q;
		end
	end

	// Edge and idle detect on synchronised levels
	assign anyRise = |(dimSync_q & ~dimPrev_q);
	assign allLow  = (dimSync_q == '0);

	// ------------------------------------------------------------
	// Gate decode
	// ------------------------------------------------------------
	// Priority decoder shared by run path
	function automatic ldol_dim_t decodeGates(input ldol_dim_t d);
		ldol_dim_t g;
		g = '0;
		if (d.three) begin
			g.three = 1'b1;
		end else if (d.two) begin
			g.two = 1'b1;
		end else begin
			g.one = d.one;
		end
		return g;
	endfunction : decodeGates

	// ------------------------------------------------------------
	// Start-up sequencing
	// ------------------------------------------------------------
	ldol_state_t state_q;
	logic        recoveryDone;

	assign recoveryDone = (loadSenseMv >= `LDOL_LOAD_DONE_MV) ||
	                      (softStartMv >= `LDOL_SS_DONE_MV);

	// Sequencer, fault returns to idle
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			state_q <= LDOL_IDLE;
		end else if (clkEn) begin
			if (faultIn) begin
				state_q <= LDOL_IDLE;
			end else begin
				unique case (state_q)
					LDOL_IDLE: begin
						if (anyRise) state_q <= LDOL_RECOVER;
					end
					LDOL_RECOVER: begin
						if (recoveryDone) state_q <= LDOL_RUN;
					end
					LDOL_RUN: begin
					end
				endcase
			end
		end
	end

	// soft-start held discharged while faulted or idle
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			softStartRelease <= 1'b0;
		end else if (clkEn) begin
			softStartRelease <= !faultIn && (state_q != LDOL_IDLE ||
			                                 anyRise);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			recoveryActive <= 1'b0;
			senseLimitMv   <= '0;
		end else if (clkEn) begin
			recoveryActive <= !faultIn && (state_q == LDOL_RECOVER) && !recoveryDone;
			senseLimitMv   <= (!faultIn && state_q == LDOL_RECOVER && !recoveryDone) ?
			                  `LDOL_RECOVERY_SENSE_MV : 16'h0000;
		end
	end

	// Gates and switch enable
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			dimGate  <= '0;
			switchEn <= 1'b0;
		end else if (clkEn) begin
			if (faultIn || state_q == LDOL_IDLE) begin
				dimGate  <= (!faultIn && anyRise) ? 3'b111 : 3'b000;
				switchEn <= !faultIn && anyRise;
			end else if (state_q == LDOL_RECOVER && !recoveryDone) begin
				dimGate  <= 3'b111;
				switchEn <= 1'b1;
			end else if (allLow) begin
				dimGate  <= '0;
				switchEn <= 1'b0;
			end else begin
				dimGate  <= decodeGates(dimSync_q);
				switchEn <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// Synchronisation and switch edge
	// ------------------------------------------------------------
	logic                  syncPrev_q;
	logic [SYNC_DELAY-1:0] edgePipe_q;
	logic                  syncEdge;

	assign syncEdge = syncIn && !syncPrev_q;

	// sync edges delayed by fixed pipeline
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			syncPrev_q <= 1'b0;
			edgePipe_q <= '0;
			switchEdge <= 1'b0;
		end else if (clkEn) begin
			syncPrev_q <= syncIn;
			edgePipe_q <= {edgePipe_q[SYNC_DELAY-2:0], syncEdge};
			switchEdge <= switchEn && (edgePipe_q[SYNC_DELAY-1] || (!syncIn && !syncPrev_q && oscTick));
		end
	end

	// ------------------------------------------------------------
	// Frequency foldback
	// ------------------------------------------------------------
	ldol_freq_scale u_scale (
		.ref_clk    (ref_clk),
		.rst_n      (rst_n),
		.clkEn      (clkEn),
		.feedbackMv (feedbackNodeMv),
		.freqPct    (freqPct)
	);

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	sequence runAllLow;
		clkEn && state_q == LDOL_RUN && !faultIn && allLow;
	endsequence

	a_idle_gates_low: assert property (runAllLow |=> dimGate == '0 && !switchEn)
		else $error("gates not low with inputs idle");
	a_start_gates_high: assert property (clkEn && state_q == LDOL_IDLE && !faultIn && anyRise
		|=> dimGate == 3'b111 && switchEn && softStartRelease)
		else $error("start did not force gates high");
	a_recovery_limit: assert property (recoveryActive |-> senseLimitMv == 16'h0030
		&& dimGate == 3'b111)
		else $error("recovery target wrong");
	a_recovery_end: assert property (clkEn && state_q == LDOL_RECOVER && recoveryDone
		&& !faultIn |=> state_q == LDOL_RUN)
		else $error("recovery did not end");
	a_decode_three: assert property (clkEn && state_q == LDOL_RUN && !faultIn && dimSync_q.three
		|=> dimGate == 3'b100)
		else $error("priority decode wrong");
	a_fault_discharge: assert property (clkEn && faultIn |=> !softStartRelease
		&& state_q == LDOL_IDLE)
		else $error("fault did not discharge soft-start");
	a_sync_delay: assert property (clkEn && syncEdge && switchEn ##1 clkEn[*2] ##0 switchEn
		|=> switchEdge)
		else $error("sync edge not followed");
	a_sync_path: assert property (clkEn && $rose(dimSync_q.one) && $past(clkEn)
		|-> $past(dimMeta_q.one))
		else $error("synchroniser skipped");
	a_fold_floor: assert property (clkEn && feedbackNodeMv == 16'h0000 |=> freqPct == 8'h0a)
		else $error("foldback floor wrong");
endmodule : ldol_top
`default_nettype wire

// *** verification/ldol_dim_source.sv ***
/*
 Dimming source model: the three dimming levels and the sync clock.
 Assumes the bench sets pattern and syncOn just after falling edges.
*/
`timescale 1ns/1ps
`default_nettype none
module ldol_dim_source (
	// Clock and commands
	input  wire logic                ref_clk,
	input  wire ldol_pkg::ldol_dim_t pattern,
	input  wire logic                syncOn,
	// Pins toward the block
	output ldol_pkg::ldol_dim_t      dimIn,
	output logic                     syncIn
);
	import ldol_pkg::*;
	logic [2:0] divQ = 3'h0;
	// Levels follow the bench, which moves them on falling edges only
	assign dimIn = pattern;
	always @(negedge ref_clk) begin
		divQ <= divQ + 3'h1;
	end
	assign syncIn = syncOn & divQ[2];
endmodule : ldol_dim_source
`default_nettype wire

// *** verification/testbench.sv ***
/*
 Self-checking bench for the LED dimming output logic.
 Assumes the design files and the dimming source model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import ldol_pkg::*;
	// ------------------------------
	// Signals
	// ------------------------------
	logic        ref_clk      = 1'b0;
	logic        rst_n        = 1'b0;
	logic        faultIn      = 1'b0;
	logic        clkEn        = 1'b1;
	logic        oscTick      = 1'b0;
	logic        oscOn        = 1'b1;
	logic        syncOn       = 1'b0;
	logic [15:0] loadMv       = 16'h0000;
	logic [15:0] ssMv         = 16'h0000;
	logic [15:0] fbMv         = 16'h0000;
	logic [4:0]  divQ         = 5'h00;
	ldol_dim_t   pattern      = 3'h0;
	ldol_dim_t   dimIn;
	ldol_dim_t   dimGate;
	logic        syncIn, switchEn, ssRel, recov, swEdge;
	logic [15:0] limMv;
	logic [7:0]  freqPct;
	int          n_mismatch   = 0;
	int          total_checks = 0;
	wire  [5:0]  st           = {dimGate, switchEn, ssRel, recov};
	// Clock, and an oscillator tick every 32 cycles
	always #2.5 ref_clk = ~ref_clk;
	always @(negedge ref_clk) begin
		divQ <= divQ + 5'h01;
		oscTick <= oscOn & (divQ == 5'h00);
	end
	ldol_dim_source src (.ref_clk(ref_clk), .pattern(pattern), .syncOn(syncOn),
		.dimIn(dimIn), .syncIn(syncIn));
	ldol_top #(.SYNC_DELAY(2)) DUT (.ref_clk(ref_clk), .rst_n(rst_n), .clkEn(clkEn),
		.dimIn(dimIn), .faultIn(faultIn), .loadSenseMv(loadMv), .softStartMv(ssMv),
		.feedbackNodeMv(fbMv), .syncIn(syncIn), .oscTick(oscTick), .dimGate(dimGate),
		.switchEn(switchEn), .softStartRelease(ssRel), .recoveryActive(recov),
		.senseLimitMv(limMv), .switchEdge(swEdge), .freqPct(freqPct));
	// ------------------------------
	// Helpers
	// ------------------------------
	task automatic tick(input int n);
		repeat (n) @(negedge ref_clk);
	endtask : tick
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic wrap_up();
		$display("checks %0d, mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : wrap_up
	// Count switch edges over n cycles
	task automatic count(input int n, output int c);
		c = 0;
		repeat (n) begin
			tick(1);
			c += int'(swEdge === 1'b1);
		end
	endtask : count
	// Cycles from a sync rise to the next switch edge
	task automatic delay(output int d);
		logic last;
		int   w;
		last = 1'b1;
		d = 0;
		w = 0;
		while (w < 20 && !(syncIn === 1'b1 && !last)) begin
			last = syncIn;
			tick(1);
			w++;
		end
		while (swEdge !== 1'b1 && d < 20) begin
			tick(1);
			d++;
		end
		if (w == 20 || d == 20) begin
			n_mismatch++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, d, 2);
			wrap_up();
		end
	endtask : delay
	// Hold reset for twelve cycles, check idle outputs, release
	task automatic t_reset();
		rst_n = 1'b0;
		tick(12);
		chk(16'({st, freqPct}), 16'h000a);
		rst_n = 1'b1;
		$display("reset done");
	endtask : t_reset
	// ------------------------------
	// Scenarios
	// ------------------------------
	task automatic t_start();
		pattern = 3'h1;
		tick(5);
		chk(16'({st, limMv[7:0]}), 16'h3f30);
		chk(limMv, 16'h0030);
		pattern = 3'h4;
		loadMv = 16'h0008;
		tick(5);
		chk(16'(st), 16'h003f);
		loadMv = 16'h0009;
		tick(3);
		chk(16'({st, limMv[7:0]}), 16'h2600);
		$display("start done");
	endtask : t_start
	task automatic t_decode();
		logic [3:0] e;
		for (int i = 0; i < 8; i++) begin
			pattern = 3'(i);
			tick(5);
			e = i[2] ? 4'h9 : i[1] ? 4'h5 : i[0] ? 4'h3 : 4'h0;
			chk(16'({dimGate, switchEn}), 16'(e));
		end
		$display("decode done");
	endtask : t_decode
	task automatic t_fault();
		faultIn = 1'b1;
		loadMv = 16'h0000;
		tick(3);
		chk(16'(st), 16'h0000);
		faultIn = 1'b0;
		pattern = 3'h0;
		tick(5);
		pattern = 3'h2;
		tick(5);
		chk(16'(st), 16'h003f);
		ssMv = 16'h0dac;
		tick(3);
		chk(16'({st, limMv[7:0]}), 16'h1600);
		$display("fault done");
	endtask : t_fault
	// Clock enable low freezes decode and foldback
	task automatic t_hold();
		clkEn = 1'b0;
		pattern = 3'h4;
		fbMv = 16'h0190;
		tick(6);
		chk(16'({st, freqPct}), 16'h160a);
		clkEn = 1'b1;
		tick(5);
		chk(16'({st, freqPct}), 16'h2664);
		$display("hold done");
	endtask : t_hold
	// Mid-run reset, then restart with soft-start already at 3.5V so recovery ends at once
	task automatic t_restart();
		t_reset();
		tick(3);
		chk(16'(st), 16'h003e);
		tick(2);
		chk(16'({st, limMv[7:0]}), 16'h2600);
		$display("restart done");
	endtask : t_restart
	task automatic t_fold();
		logic [15:0] fb [4] = '{16'h0000, 16'h00c8, 16'h0190, 16'h03e8};
		logic [7:0]  ex [4] = '{8'h0a, 8'h37, 8'h64, 8'h64};
		for (int i = 0; i < 4; i++) begin
			fbMv = fb[i];
			tick(3);
			chk(16'(freqPct), 16'(ex[i]));
		end
		$display("foldback done");
	endtask : t_fold
	task automatic t_sync();
		int c, d1, d2;
		oscOn = 1'b0;
		tick(8);
		count(40, c);
		chk(16'(c), 16'h0000);
		oscOn = 1'b1;
		tick(32);
		count(64, c);
		chk(16'(c), 16'h0002);
		oscOn = 1'b0;
		tick(8);
		syncOn = 1'b1;
		delay(d1);
		delay(d2);
		chk(16'(d1), 16'h0002);
		chk(16'(d2), 16'h0002);
		count(64, c);
		chk(16'(c), 16'h0008);
		syncOn = 1'b0;
		$display("sync done");
	endtask : t_sync
	// Main sequence
	initial begin
		t_reset();
		t_start();
		t_decode();
		t_fault();
		t_hold();
		t_fold();
		t_restart();
		t_sync();
		wrap_up();
	end
endmodule : testbench
`default_nettype wire
